// ### verilog/acls_pkg.sv
// ----------------------------------------------------------------------------
// Package for the audio configuration and link status register pair
// ----------------------------------------------------------------------------
// Holds register offsets, bit positions, reset values and carrier structs.
// Assumes an 8-bit register address space reached through a simple port.
package acls_pkg;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_AUDIO_CONFIGURATION = 8'h55;
  localparam logic [7:0] ADDR_LINK_AND_INPUT_STATUS = 8'h5a;

  // --------------------------------------------------------------------------
  // Reset values and write mask
  // --------------------------------------------------------------------------
  localparam logic [7:0] RESET_AUDIO_CONFIGURATION = 8'h0c;
  localparam logic [7:0] RESET_LINK_AND_INPUT_STATUS = 8'h00;
  localparam logic [7:0] AUDIO_CFG_WRITE_MASK = 8'hcf;  // Bits 5:4 reserved
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [1:0] PORT_MODE_IDLE = 2'h0;

  // --------------------------------------------------------------------------
  // Audio configuration bit positions
  // --------------------------------------------------------------------------
  localparam int CFG_TDM_TO_PARALLEL = 7;
  localparam int CFG_HDMI_I2S_OUT = 6;
  localparam int CFG_RESET_ON_TYPE = 3;
  localparam int CFG_RESET_ON_AUDIO_INFOFRAME = 2;
  localparam int CFG_RESET_ON_VIDEO_INFOFRAME = 1;
  localparam int CFG_RESET_ON_CLOCK_REGEN = 0;

  // --------------------------------------------------------------------------
  // Audio source selection encodings
  // --------------------------------------------------------------------------
  localparam logic AUDIO_SOURCE_HDMI = 1'b0;
  localparam logic AUDIO_SOURCE_LOCAL = 1'b1;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  // Raw status levels from the link and HDMI receiver logic
  typedef struct packed {
    logic downstream_link_ready;
    logic serial_transmit_active;
    logic [1:0] serial_port_mode;
    logic tmds_data_recovered;
    logic hdmi_pll_locked;
    logic hdmi_clock_present;
    logic input_frequency_settled;
  } acls_status_t;

  // Metadata reports from the HDMI packet decoder, each with its strobe
  typedef struct packed {
    logic type_valid;
    logic [3:0] audio_type;
    logic aif_valid;
    logic [7:0] aif_checksum;
    logic avi_valid;
    logic [7:0] avi_checksum;
    logic acr_valid;
    logic [19:0] acr_n;
    logic [19:0] acr_cts;
  } acls_meta_t;

endpackage

// ### verilog/acls_regs.sv
// ----------------------------------------------------------------------------
// Audio configuration and link / input status register pair
// ----------------------------------------------------------------------------
// Register port is synchronous to clk (the serial control bus front end).
// Status levels come from other clock domains; metadata reports from clk logic.
//
// Operation
// RULE_01: Bit 7 enables TDM conversion and its clock
// RULE_02: Bit 6 drives HDMI audio on I2S pins
// RULE_03: Bit 3 resets FIFO on audio type change
// RULE_04: Bit 2 resets FIFO on audio infoframe change
// RULE_05: Bit 1 resets FIFO on video infoframe change
// RULE_06: Bit 0 resets FIFO on N/CTS change
// RULE_07: Status 7 shows downstream link ready
// RULE_08: Status 6 shows transmitter active, receiver locked
// RULE_09: Status 5:4 show port mode when transmitting
// RULE_10: Status 3 shows TMDS data recovered
// RULE_11: Status 2 shows HDMI PLL locked
// RULE_12: Status 0 shows input frequency stable
// RULE_13: Source select picks HDMI or local I2S audio
// RULE_14: Status 1 shows no HDMI clock present
`timescale 1ns/1ps

module acls_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Status levels from other domains
  input wire acls_pkg::acls_status_t status_in,
  // Metadata reports and audio source selection
  input wire acls_pkg::acls_meta_t meta_in,
  input wire logic audio_source_local,
  // Audio path controls
  output logic tdm_conversion_enable,
  output logic audio_clock_from_tdm,
  output logic hdmi_i2s_output_enable,
  output logic audio_from_local_pins,
  output logic audio_fifo_reset
);

  // --------------------------------------------------------------------------
  // Change detection
  // --------------------------------------------------------------------------
  // A report counts only when enabled and a previous report exists to compare
  function automatic logic changed(input logic enable, input logic strobe, input logic seen,
                                   input logic differs);
    changed = enable & strobe & seen & differs;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0] audio_configuration;
  acls_pkg::acls_status_t sync_stage1;
  acls_pkg::acls_status_t sync_stage2;
  logic [7:0] link_and_input_status;
  logic [3:0] last_type;
  logic [7:0] last_aif;
  logic [7:0] last_avi;
  logic [39:0] last_acr;
  logic [3:0] seen;

  // --------------------------------------------------------------------------
  // Decode and selection
  // --------------------------------------------------------------------------
  wire cfg_hit = reg_addr == acls_pkg::ADDR_AUDIO_CONFIGURATION;
  wire sts_hit = reg_addr == acls_pkg::ADDR_LINK_AND_INPUT_STATUS;
  wire [7:0] next_audio_configuration = reg_wdata & acls_pkg::AUDIO_CFG_WRITE_MASK;
  wire [7:0] next_rdata = cfg_hit ? audio_configuration :
                          sts_hit ? link_and_input_status : acls_pkg::READ_UNMAPPED;
  // Transmit status needs a valid input and a settled link
  wire tx_shown = sync_stage2.serial_transmit_active & sync_stage2.tmds_data_recovered
                  & sync_stage2.downstream_link_ready;  // [RULE_08]
  wire [1:0] mode_shown = tx_shown ? sync_stage2.serial_port_mode : acls_pkg::PORT_MODE_IDLE;  // [RULE_09]
  wire [7:0] next_status = {sync_stage2.downstream_link_ready,  // [RULE_07]
                            tx_shown,
                            mode_shown,
                            sync_stage2.tmds_data_recovered,  // [RULE_10]
                            sync_stage2.hdmi_pll_locked,  // [RULE_11]
                            ~sync_stage2.hdmi_clock_present,  // [RULE_14]
                            sync_stage2.input_frequency_settled};  // [RULE_12]
  wire [39:0] acr_now = {meta_in.acr_n, meta_in.acr_cts};
  wire type_chg = changed(audio_configuration[acls_pkg::CFG_RESET_ON_TYPE], meta_in.type_valid, seen[0],
                          meta_in.audio_type != last_type);  // [RULE_03]
  wire aif_chg = changed(audio_configuration[acls_pkg::CFG_RESET_ON_AUDIO_INFOFRAME], meta_in.aif_valid,
                         seen[1], meta_in.aif_checksum != last_aif);  // [RULE_04]
  wire avi_chg = changed(audio_configuration[acls_pkg::CFG_RESET_ON_VIDEO_INFOFRAME], meta_in.avi_valid,
                         seen[2], meta_in.avi_checksum != last_avi);  // [RULE_05]
  wire acr_chg = changed(audio_configuration[acls_pkg::CFG_RESET_ON_CLOCK_REGEN], meta_in.acr_valid,
                         seen[3], acr_now != last_acr);  // [RULE_06]
  wire next_fifo_reset = type_chg | aif_chg | avi_chg | acr_chg;
  // I2S output of HDMI audio is only honoured with HDMI as the source
  wire next_i2s_out = audio_configuration[acls_pkg::CFG_HDMI_I2S_OUT]
                      & (audio_source_local == acls_pkg::AUDIO_SOURCE_HDMI);  // [RULE_02]

  // --------------------------------------------------------------------------
  // Configuration register and register reads
  // --------------------------------------------------------------------------
  // Read data lands one cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      audio_configuration <= acls_pkg::RESET_AUDIO_CONFIGURATION;
      reg_rdata <= acls_pkg::READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      if (reg_write && cfg_hit) begin
        audio_configuration <= next_audio_configuration;
      end
      reg_rdata <= reg_read ? next_rdata : acls_pkg::READ_UNMAPPED;
      reg_rvalid <= reg_read;
    end
  end

  // --------------------------------------------------------------------------
  // Status synchronisers
  // --------------------------------------------------------------------------
  // Two flops per level; port mode bits may tear for one cycle on a change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_stage1 <= '0;
      sync_stage2 <= '0;
      link_and_input_status <= acls_pkg::RESET_LINK_AND_INPUT_STATUS;
    end else begin
      sync_stage1 <= status_in;
      sync_stage2 <= sync_stage1;
      link_and_input_status <= next_status;
    end
  end

  // --------------------------------------------------------------------------
  // Metadata history
  // --------------------------------------------------------------------------
  // The first report after reset only primes the history, no FIFO reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_type <= '0;
      last_aif <= '0;
      last_avi <= '0;
      last_acr <= '0;
      seen <= '0;
    end else begin
      if (meta_in.type_valid) last_type <= meta_in.audio_type;
      if (meta_in.aif_valid) last_aif <= meta_in.aif_checksum;
      if (meta_in.avi_valid) last_avi <= meta_in.avi_checksum;
      if (meta_in.acr_valid) last_acr <= acr_now;
      seen <= seen | {meta_in.acr_valid, meta_in.avi_valid, meta_in.aif_valid, meta_in.type_valid};
    end
  end

  // --------------------------------------------------------------------------
  // Audio path outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tdm_conversion_enable <= 1'b0;
      audio_clock_from_tdm <= 1'b0;
      hdmi_i2s_output_enable <= 1'b0;
      audio_from_local_pins <= 1'b0;
      audio_fifo_reset <= 1'b0;
    end else begin
      tdm_conversion_enable <= audio_configuration[acls_pkg::CFG_TDM_TO_PARALLEL];  // [RULE_01]
      audio_clock_from_tdm <= audio_configuration[acls_pkg::CFG_TDM_TO_PARALLEL];  // [RULE_01]
      hdmi_i2s_output_enable <= next_i2s_out;
      audio_from_local_pins <= audio_source_local;  // [RULE_13]
      audio_fifo_reset <= next_fifo_reset;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Release edge skipped: the flops still load reset values on that edge
  chk_tdm_enable_follows: assert property (  // [RULE_01]
    !$past(rst) |-> tdm_conversion_enable == $past(audio_configuration[acls_pkg::CFG_TDM_TO_PARALLEL])
        && audio_clock_from_tdm == tdm_conversion_enable)
    else $error("TDM enable does not follow config bit");
  chk_i2s_source_gate: assert property (  // [RULE_02]
    audio_source_local == acls_pkg::AUDIO_SOURCE_LOCAL |=> !hdmi_i2s_output_enable)
    else $error("HDMI I2S output on with local source");
  chk_type_fifo_reset: assert property (  // [RULE_03]
    meta_in.type_valid && seen[0] && meta_in.audio_type != last_type
    && audio_configuration[acls_pkg::CFG_RESET_ON_TYPE] |=> audio_fifo_reset)
    else $error("Audio type change missed FIFO reset");
  chk_aif_fifo_reset: assert property (  // [RULE_04]
    meta_in.aif_valid && seen[1] && meta_in.aif_checksum != last_aif
    && audio_configuration[acls_pkg::CFG_RESET_ON_AUDIO_INFOFRAME] |=> audio_fifo_reset)
    else $error("Audio infoframe change missed FIFO reset");
  chk_avi_fifo_reset: assert property (  // [RULE_05]
    meta_in.avi_valid && seen[2] && meta_in.avi_checksum != last_avi
    && audio_configuration[acls_pkg::CFG_RESET_ON_VIDEO_INFOFRAME] |=> audio_fifo_reset)
    else $error("Video infoframe change missed FIFO reset");
  chk_no_spurious_reset: assert property (  // [RULE_05]
    !(meta_in.type_valid || meta_in.aif_valid || meta_in.avi_valid || meta_in.acr_valid)
    |=> !audio_fifo_reset)
    else $error("FIFO reset without a report");
  chk_acr_fifo_reset: assert property (  // [RULE_06]
    meta_in.acr_valid && seen[3] && acr_now != last_acr
    && audio_configuration[acls_pkg::CFG_RESET_ON_CLOCK_REGEN] |=> audio_fifo_reset)
    else $error("N/CTS change missed FIFO reset");
  chk_link_ready_lag: assert property (  // [RULE_07]
    $stable(status_in.downstream_link_ready) [*3] |=> link_and_input_status[7] == $past(status_in.downstream_link_ready))
    else $error("Link ready bit lags wrongly");
  chk_tx_needs_input: assert property (  // [RULE_08]
    link_and_input_status[6] |-> link_and_input_status[3] && link_and_input_status[7])
    else $error("Transmit status without valid input");
  chk_mode_idle_off: assert property (  // [RULE_09]
    !link_and_input_status[6] |-> link_and_input_status[5:4] == acls_pkg::PORT_MODE_IDLE)
    else $error("Port mode shown while not transmitting");
  chk_no_clock_flag: assert property (  // [RULE_14]
    !$past(rst) |-> link_and_input_status[1] == !$past(sync_stage2.hdmi_clock_present))
    else $error("No-clock bit wrong");

  cov_fifo_reset: cover property (audio_fifo_reset);
  cov_transmit_active: cover property (link_and_input_status[6]);
  cov_cfg_write_read: cover property (reg_write && cfg_hit ##1 reg_read && cfg_hit);

endmodule  // acls_regs

// ### test/acls_far_model.sv
// ----------------------------------------------------------------------------
// Far-end deserializer model for the link status levels
// ----------------------------------------------------------------------------
// Behavioural model of the downstream receiver seen through the status levels.
// Assumes connect, lock and mode requests come from the bench on clk.
`timescale 1ns/1ps

module acls_far_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench requests
  input wire logic connect,
  input wire logic lock,
  input wire logic [1:0] mode,
  // Link status levels
  output logic link_ready,
  output logic tx_active,
  output logic [1:0] port_mode
);
  // Ready one cycle after connect; transmit only while ready and locked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_ready <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      link_ready <= connect;
      tx_active <= connect & link_ready & lock;
    end
  end

  // Mode means nothing while idle, so show a wrong value then
  assign port_mode = tx_active ? mode : ~mode;
endmodule // acls_far_model

// ### test/acls_regs_tb.sv
// ----------------------------------------------------------------------------
// Testbench for the audio configuration and link status registers
// ----------------------------------------------------------------------------
// Drives the register port, status levels and metadata reports.
// Assumes the far-end model supplies link ready, transmit and port mode.
`timescale 1ns/1ps

module acls_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_write = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  acls_pkg::acls_meta_t meta = '0;
  logic src_local = 1'b0;
  logic tdm_en, tdm_clk, i2s_en, local_pins, fifo_rst;
  logic connect = 1'b0, lock = 1'b0, lr, tx;
  logic [1:0] mode = 2'h2, pm;
  logic tmds = 1'b0, pll = 1'b0, clkp = 1'b1, freq = 1'b0;
  int error_cnt = 0;
  int compares = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  acls_regs u_acls_regs (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .status_in({lr, tx, pm, tmds, pll, clkp, freq}), .meta_in(meta), .audio_source_local(src_local),
    .tdm_conversion_enable(tdm_en), .audio_clock_from_tdm(tdm_clk), .hdmi_i2s_output_enable(i2s_en),
    .audio_from_local_pins(local_pins), .audio_fifo_reset(fifo_rst));

  acls_far_model u_acls_far_model (.clk(clk), .rst(rst), .connect(connect), .lock(lock), .mode(mode),
    .link_ready(lr), .tx_active(tx), .port_mode(pm));

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Answer stands one cycle after the read edge, then falls back to zero
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, exp);
    @(posedge clk);
    #1;
    chk({7'h00, reg_rvalid}, 8'h00);
    chk(reg_rdata, acls_pkg::READ_UNMAPPED);
  endtask

  // Status passes two sync flops and a register before it can be read
  task automatic st(input logic [7:0] exp);
    repeat (5) @(posedge clk);
    rd(8'h5a, exp);
  endtask

  task automatic outs(input logic [7:0] exp);
    repeat (2) @(posedge clk);
    #1;
    chk({4'h0, tdm_en, tdm_clk, i2s_en, local_pins}, exp);
  endtask

  // One metadata report; kind 4 changes only the CTS field
  task automatic mt(input int k, input logic [7:0] v, input logic exp);
    @(posedge clk);
    if (k == 0) meta.audio_type <= v[3:0];
    if (k == 1) meta.aif_checksum <= v;
    if (k == 2) meta.avi_checksum <= v;
    if (k == 3) meta.acr_n <= {12'h000, v};
    if (k == 4) meta.acr_cts <= {12'h000, v};
    {meta.type_valid, meta.aif_valid, meta.avi_valid, meta.acr_valid} <= {k == 0, k == 1, k == 2, k >= 3};
    @(posedge clk);
    {meta.type_valid, meta.aif_valid, meta.avi_valid, meta.acr_valid} <= 4'h0;
    #1;
    chk({7'h00, fifo_rst}, {7'h00, exp});
    // Pulse lasts a single cycle per changing report
    @(posedge clk);
    #1;
    chk({7'h00, fifo_rst}, 8'h00);
  endtask

  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #(100 * 5000);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    outs(8'h00);
    rd(8'h55, 8'h0c);
    st(8'h00);
    rd(8'h33, 8'h00);
    $display("test reset done");
    wr(8'h55, 8'hff);
    rd(8'h55, 8'hcf);
    outs(8'h0e);
    @(posedge clk) src_local <= 1'b1;
    outs(8'h0d);
    wr(8'h5a, 8'hff);
    wr(8'h56, 8'h00);
    rd(8'h55, 8'hcf);
    wr(8'h55, 8'h00);
    outs(8'h01);
    $display("test config done");
    @(posedge clk) clkp <= 1'b0;
    st(8'h02);
    @(posedge clk) clkp <= 1'b1;
    @(posedge clk) tmds <= 1'b1;
    st(8'h08);
    @(posedge clk) pll <= 1'b1;
    st(8'h0c);
    @(posedge clk) freq <= 1'b1;
    st(8'h0d);
    @(posedge clk) connect <= 1'b1;
    st(8'h8d);
    @(posedge clk) lock <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) mode <= m[1:0];
      st(8'hcd | {2'h0, m[1:0], 4'h0});
    end
    @(posedge clk) tmds <= 1'b0;
    st(8'h85);
    $display("test status done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h55, 8'h08 >> k);
      mt(k, 8'h01, 1'b0);
      mt(k, 8'h01, 1'b0);
      mt(k, 8'h02, 1'b1);
      wr(8'h55, 8'h0f ^ (8'h08 >> k));
      mt(k, 8'h03, 1'b0);
    end
    wr(8'h55, 8'h01);
    mt(4, 8'h05, 1'b1);
    $display("test fifo done");
    // Second reset restores defaults and forgets metadata history
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(posedge clk) rst <= 1'b0;
    rd(8'h55, 8'h0c);
    mt(1, 8'h07, 1'b0);
    $display("test second reset done");
    complete_run();
  end
endmodule // acls_regs_tb
